// ===== design/hdtc_holdover_ctrl.sv
`timescale 1ns/10ps
// What this block does
// R1 - manual level: 10-bit code, upper two at 0x14B, lower eight at 0x14C
// R2 - ground trip code n sets threshold (n+1)/64 above ground; holdover
// R3 - supply trip code n sets threshold (n+1)/64 below supply; holdover
// R4 - multiplier code 0..3 at 0x14E[7:6] selects 4, 64, 1024, 16384
// R5 - tracked value updates every multiplier*count cycles; count resets 127
// R6 - with follow enabled, track only while PLL1 locked; start at 512
// R7 - forced holdover drives manual level if selected, else tracked value
// R8 - with rail detector on, a trip marks input invalid, raises switch event
// R9 - trips compare upper six tracked bits with the two trip codes
module hdtc_holdover_ctrl
    import hdtc_pkg::*;
#(
    parameter int DAC_W = HDTC_DAC_W
) (
    input wire logic hclk, // system clock, 125 MHz
    input wire logic hresetn, // async reset, active low
    input wire logic hce, // clock enable, freezes all state
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // transfer size
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    output logic hreadyout, // slave ready
    output logic [31:0] hrdata, // read data
    output logic hresp, // always OKAY
    input wire logic pd_tick, // one PLL1 phase-detector cycle
    input wire logic pll1_locked, // PLL1 lock level
    input wire logic tune_above_dac, // tuning voltage above DAC level
    output logic [9:0] dac_code, // holdover DAC code
    output logic holdover_active, // holdover forced or tripped
    output logic input_invalid, // current clock input invalid
    output logic clk_switch_event, // one-cycle switch request
    output logic irq // level interrupt
);
    if (DAC_W != HDTC_DAC_W) begin : g_chk
        $error("hdtc_holdover_ctrl: only a 10-bit DAC is served");
    end

    // every flop of the block outside the timer lives in this one record
    typedef struct packed {
        logic [7:0] upper;
        logic [7:0] lower;
        logic [5:0] gnd_trip_code;
        logic [7:0] mult_sup;
        logic [7:0] rate_cnt;
        logic rail_en;
        logic [HDTC_EV_W-1:0] status;
        logic [HDTC_EV_W-1:0] mask;
        logic [9:0] tracked;
        hdtc_mode_t mode;
        logic gnd_trip;
        logic sup_trip;
        logic [9:0] dac;
        logic sw_event;
        logic irq;
        logic dp_wr;
        logic [9:0] dp_idx;
        logic [31:0] rdata;
        logic ready;
    } hdtc_state_t;

    hdtc_state_t r;
    hdtc_state_t next_r;
    hdtc_timer_if tif ();

    // helpers below read registered state, the bus inputs and pll1_locked
    logic accept;
    logic addr_ok;
    logic [9:0] a_idx;
    logic gnd_hit;
    logic sup_hit;
    logic step;
    logic [9:0] manual;

    ////////////////////////////////////////////////////////////////////////
    // register read view, taken from the post-write state
    function automatic logic [7:0] hdtc_read(input hdtc_state_t s,
                                             input logic [9:0] idx);
        case (idx)
            HDTC_IDX_MAN_UPPER: hdtc_read = s.upper;
            HDTC_IDX_MAN_LOWER: hdtc_read = s.lower;
            HDTC_IDX_GND_TRIP: hdtc_read = {2'h0, s.gnd_trip_code};
            HDTC_IDX_MULT_SUP: hdtc_read = s.mult_sup;
            HDTC_IDX_RATE_CNT: hdtc_read = s.rate_cnt;
            HDTC_IDX_SWITCH_CTRL: hdtc_read = 8'(s.rail_en) << HDTC_RAIL_BIT;
            HDTC_IDX_STATUS: hdtc_read = 8'(s.status);
            HDTC_IDX_MASK: hdtc_read = 8'(s.mask);
            HDTC_IDX_TRACKED: hdtc_read = s.tracked[9:2];
            default: hdtc_read = 8'h00;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // tracking-rate timer hookup
    // clearing the track bit also clears the timer count
    assign tif.ce = hce;
    assign tif.pd_tick = pd_tick;
    assign tif.run = r.upper[HDTC_TRACK_BIT];
    assign tif.mult_sel = r.mult_sup[HDTC_MULT_LSB +: 2]; // R4
    assign tif.count = r.rate_cnt; // R5

    hdtc_rate_timer #(
        .CNT_W(HDTC_CNT_W)
    ) u_timer (
        .hclk(hclk),
        .hresetn(hresetn),
        .tif(tif)
    );

    ////////////////////////////////////////////////////////////////////////
    // bus decode; anything above the index field is unmapped
    // zero wait states, so hce must stay high while a transfer runs
    assign a_idx = haddr[HDTC_ADDR_TOP-1:HDTC_ADDR_LSB];
    assign addr_ok = haddr[31:HDTC_ADDR_TOP] == '0;
    assign accept = hsel && htrans[1] && hready;

    // trip compare on the DAC's own scale, top six bits
    assign gnd_hit = r.tracked[9:4] <= r.gnd_trip_code; // R2 R9
    assign sup_hit = r.tracked[9:4] >= ~r.mult_sup[5:0]; // R3 R9
    assign step = tif.tick && r.upper[HDTC_TRACK_BIT] && pll1_locked; // R6
    assign manual = {r.upper[HDTC_MAN_HI_LSB +: 2], r.lower}; // R1

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [HDTC_EV_W-1:0] ev;
        logic [HDTC_EV_W-1:0] clr;
        logic rise;
        ev = '0;
        clr = '0;
        rise = 1'b0;
        next_r = r;
        next_r.sw_event = 1'b0;
        next_r.ready = 1'b1;

        // write data phase; only whole words reach a register
        if (r.dp_wr) begin
            case (r.dp_idx)
                HDTC_IDX_MAN_UPPER: next_r.upper = hwdata[7:0]; // R1
                HDTC_IDX_MAN_LOWER: next_r.lower = hwdata[7:0]; // R1
                HDTC_IDX_GND_TRIP: next_r.gnd_trip_code = hwdata[5:0];
                HDTC_IDX_MULT_SUP: next_r.mult_sup = hwdata[7:0];
                HDTC_IDX_RATE_CNT: next_r.rate_cnt = hwdata[7:0];
                HDTC_IDX_SWITCH_CTRL: next_r.rail_en = hwdata[HDTC_RAIL_BIT];
                HDTC_IDX_MASK: next_r.mask = hwdata[HDTC_EV_W-1:0];
                default: next_r.rate_cnt = next_r.rate_cnt;
            endcase
        end

        // address phase: latch write target, capture read data
        next_r.dp_wr = accept && hwrite && addr_ok && hsize == 3'h2;
        next_r.dp_idx = a_idx;
        if (accept && !hwrite) begin
            next_r.rdata = addr_ok ? {24'h0, hdtc_read(next_r, a_idx)} : '0;
            if (addr_ok && a_idx == HDTC_IDX_STATUS) begin
                clr = r.status;
            end
        end

        // follow the tuning voltage one code at a time, clamped
        if (step) begin
            ev[HDTC_EV_UPD] = 1'b1;
            if (tune_above_dac && r.tracked != HDTC_DAC_MAX) begin
                next_r.tracked = r.tracked + 10'h001; // R6
            end else if (!tune_above_dac && r.tracked != HDTC_DAC_MIN) begin
                next_r.tracked = r.tracked - 10'h001; // R6
            end
        end

        // rail detector; a new trip is an event
        next_r.gnd_trip = r.rail_en && gnd_hit; // R2
        next_r.sup_trip = r.rail_en && sup_hit; // R3
        ev[HDTC_EV_GND] = next_r.gnd_trip && !r.gnd_trip;
        ev[HDTC_EV_SUP] = next_r.sup_trip && !r.sup_trip;
        rise = ev[HDTC_EV_GND] || ev[HDTC_EV_SUP];
        next_r.sw_event = rise; // R8

        // a tripped input stays invalid until the detector is disabled
        case (r.mode)
            HDTC_FOLLOW: begin
                if (rise) begin
                    next_r.mode = HDTC_TRIPPED; // R8
                end else if (r.upper[HDTC_FORCE_BIT]) begin
                    next_r.mode = HDTC_FORCED;
                end
            end
            HDTC_FORCED: begin
                if (rise) begin
                    next_r.mode = HDTC_TRIPPED; // R8
                end else if (!r.upper[HDTC_FORCE_BIT]) begin
                    next_r.mode = HDTC_FOLLOW;
                end
            end
            HDTC_TRIPPED: begin
                if (!r.rail_en) begin
                    next_r.mode = r.upper[HDTC_FORCE_BIT] ? HDTC_FORCED
                                                          : HDTC_FOLLOW;
                end
            end
            default: next_r.mode = HDTC_FOLLOW;
        endcase

        // holdover with manual select shows the manual level
        if (next_r.mode != HDTC_FOLLOW && next_r.upper[HDTC_MAN_SEL_BIT]) begin
            next_r.dac = {next_r.upper[HDTC_MAN_HI_LSB +: 2], next_r.lower};
        end else begin
            next_r.dac = next_r.tracked; // R7
        end

        // set wins over the read clear
        next_r.status = (r.status & ~clr) | ev;
        next_r.irq = |(next_r.status & next_r.mask);
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '{upper: HDTC_RST_UPPER, lower: HDTC_RST_LOWER,
                   gnd_trip_code: HDTC_RST_TRIP, mult_sup: HDTC_RST_MULT_SUP,
                   rate_cnt: HDTC_RST_CNT, tracked: HDTC_TRACK_START,
                   mode: HDTC_FOLLOW, dac: HDTC_TRACK_START, ready: 1'b1,
                   default: '0}; // R5 R6
        end else if (hce) begin
            r <= next_r;
        end
    end

    // outputs straight from the state register; hresp tied low
    assign hreadyout = r.ready;
    assign hrdata = r.rdata;
    assign hresp = 1'b0;
    assign dac_code = r.dac;
    assign holdover_active = r.mode != HDTC_FOLLOW;
    assign input_invalid = r.mode == HDTC_TRIPPED;
    assign clk_switch_event = r.sw_event;
    assign irq = r.irq;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_man_level_out: assert property ( // R1
        holdover_active && r.upper[HDTC_MAN_SEL_BIT] |-> dac_code == manual)
        else $error("manual level not on the DAC");
    a_tracked_out: assert property ( // R7
        !(holdover_active && r.upper[HDTC_MAN_SEL_BIT])
        |-> dac_code == r.tracked)
        else $error("tracked value not on the DAC");
    a_gnd_trip_hold: assert property ( // R2
        hce && r.rail_en && gnd_hit && !r.gnd_trip && !r.dp_wr
        |=> input_invalid && holdover_active && r.status[HDTC_EV_GND])
        else $error("ground trip did not enter holdover");
    a_sup_trip_hold: assert property ( // R3
        hce && r.rail_en && sup_hit && !r.sup_trip && !r.dp_wr
        |=> input_invalid && holdover_active && r.status[HDTC_EV_SUP])
        else $error("supply trip did not enter holdover");
    a_trip_event: assert property ( // R8
        clk_switch_event |-> input_invalid && r.rail_en
        && (r.gnd_trip || r.sup_trip))
        else $error("switch event without a trip");
    a_no_rail_trip: assert property ( // R8
        !r.rail_en && hce ##1 !r.rail_en |-> !r.gnd_trip && !r.sup_trip)
        else $error("trip with rail detector off");
    a_hold_unlocked: assert property ( // R6
        !pll1_locked |=> r.tracked == $past(r.tracked))
        else $error("tracking while PLL1 unlocked");
    a_track_step: assert property ( // R6
        hce && step && tune_above_dac && r.tracked != HDTC_DAC_MAX
        |=> r.tracked == $past(r.tracked) + 10'h001)
        else $error("tracked code did not step up");
    a_irq_level: assert property (
        irq == |(r.status & r.mask))
        else $error("interrupt level disagrees with status");

    // start point and scale of the trip compare
    a_track_start: assert property ( // R6
        $rose(hresetn) |-> r.tracked == HDTC_TRACK_START)
        else $error("tracking did not start at mid scale");

    a_gnd_scale: assert property ( // R2
        hce && r.rail_en && 11'(r.tracked) <
        (11'(r.gnd_trip_code) + 11'h001) << (HDTC_DAC_W - HDTC_TRIP_W)
        |=> r.gnd_trip)
        else $error("ground threshold missed");

    a_sup_scale: assert property ( // R3
        hce && r.rail_en && 11'(r.tracked) + ((11'(r.mult_sup[5:0])
        + 11'h001) << (HDTC_DAC_W - HDTC_TRIP_W)) > 11'(HDTC_DAC_MAX)
        |=> r.sup_trip)
        else $error("supply threshold missed");

    // forcing and release
    a_forced_hold: assert property ( // R7
        hce && r.upper[HDTC_FORCE_BIT] && !r.rail_en |=> holdover_active)
        else $error("forced holdover not entered");

    a_release: assert property ( // R7
        hce && !r.upper[HDTC_FORCE_BIT] && !r.rail_en |=> !holdover_active)
        else $error("holdover not released");

    a_invalid_hold: assert property ( // R8
        input_invalid |-> holdover_active)
        else $error("invalid input outside holdover");

    a_man_write: assert property ( // R1
        hce && r.dp_wr && r.dp_idx == HDTC_IDX_MAN_LOWER
        |=> r.lower == $past(hwdata[7:0]))
        else $error("manual level write lost");

    // tracking gates and clamps
    a_track_off: assert property ( // R6
        hce && !r.upper[HDTC_TRACK_BIT] |=> r.tracked == $past(r.tracked))
        else $error("tracking while disabled");

    a_count_zero: assert property ( // R5
        $past(hce) && r.rate_cnt == '0 && $past(r.rate_cnt) == '0
        |=> r.tracked == $past(r.tracked))
        else $error("update with a zero count");

    a_step_down: assert property ( // R6
        hce && step && !tune_above_dac && r.tracked != HDTC_DAC_MIN
        |=> r.tracked == $past(r.tracked) - 10'h001)
        else $error("tracked code did not step down");

    a_clamp_top: assert property ( // R6
        step && tune_above_dac && r.tracked == HDTC_DAC_MAX
        |=> r.tracked == HDTC_DAC_MAX)
        else $error("tracked code wrapped");

    a_upd_event: assert property ( // R5
        hce && step |=> r.status[HDTC_EV_UPD])
        else $error("update event not recorded");

    c_manual_hold: cover property (
        holdover_active && r.upper[HDTC_MAN_SEL_BIT]);
    c_trip_event: cover property (clk_switch_event);
    c_track_step: cover property (hce && step ##1 r.status[HDTC_EV_UPD]);
    c_sup_trip: cover property (r.sup_trip && clk_switch_event);
    c_status_clear: cover property (accept && !hwrite
        && a_idx == HDTC_IDX_STATUS && r.status != '0);

endmodule

// ===== design/hdtc_pkg.sv
package hdtc_pkg;

    // word index of each register; byte address is four times the index
    localparam logic [9:0] HDTC_IDX_MAN_UPPER = 10'h14B;
    localparam logic [9:0] HDTC_IDX_MAN_LOWER = 10'h14C;
    localparam logic [9:0] HDTC_IDX_GND_TRIP = 10'h14D;
    localparam logic [9:0] HDTC_IDX_MULT_SUP = 10'h14E;
    localparam logic [9:0] HDTC_IDX_RATE_CNT = 10'h14F;
    localparam logic [9:0] HDTC_IDX_SWITCH_CTRL = 10'h150;
    localparam logic [9:0] HDTC_IDX_STATUS = 10'h160;
    localparam logic [9:0] HDTC_IDX_MASK = 10'h161;
    localparam logic [9:0] HDTC_IDX_TRACKED = 10'h162;

    localparam int HDTC_IDX_W = 10;
    localparam int HDTC_ADDR_LSB = 2;
    localparam int HDTC_ADDR_TOP = HDTC_ADDR_LSB + HDTC_IDX_W;

    // field positions
    localparam int HDTC_MAN_HI_LSB = 0;
    localparam int HDTC_MAN_SEL_BIT = 2;
    localparam int HDTC_FORCE_BIT = 3;
    localparam int HDTC_TRACK_BIT = 4;
    localparam int HDTC_RAIL_BIT = 2;
    localparam int HDTC_MULT_LSB = 6;
    localparam int HDTC_TRIP_W = 6;
    localparam int HDTC_DAC_W = 10;
    localparam int HDTC_CNT_W = 8;

    // reset values
    localparam logic [7:0] HDTC_RST_UPPER = 8'h06;
    localparam logic [7:0] HDTC_RST_LOWER = 8'h00;
    localparam logic [5:0] HDTC_RST_TRIP = 6'h00;
    localparam logic [7:0] HDTC_RST_MULT_SUP = 8'h00;
    localparam logic [7:0] HDTC_RST_CNT = 8'h7F;
    localparam logic [9:0] HDTC_TRACK_START = 10'h200;
    localparam logic [9:0] HDTC_DAC_MAX = 10'h3FF;
    localparam logic [9:0] HDTC_DAC_MIN = 10'h000;

    // sticky event bits
    localparam int HDTC_EV_GND = 0;
    localparam int HDTC_EV_SUP = 1;
    localparam int HDTC_EV_UPD = 2;
    localparam int HDTC_EV_W = 3;

    // multiplier as a shift: 4, 64, 1024, 16384
    localparam logic [4:0] HDTC_SHIFT_X4 = 5'h02;
    localparam logic [4:0] HDTC_SHIFT_X64 = 5'h06;
    localparam logic [4:0] HDTC_SHIFT_X1024 = 5'h0A;
    localparam logic [4:0] HDTC_SHIFT_X16384 = 5'h0E;
    localparam int HDTC_SHIFT_MAX = 14;

    typedef enum logic [1:0] {
        HDTC_FOLLOW,
        HDTC_FORCED,
        HDTC_TRIPPED
    } hdtc_mode_t;

    function automatic logic [4:0] hdtc_mult_shift(input logic [1:0] sel);
        case (sel)
            2'h0: hdtc_mult_shift = HDTC_SHIFT_X4;
            2'h1: hdtc_mult_shift = HDTC_SHIFT_X64;
            2'h2: hdtc_mult_shift = HDTC_SHIFT_X1024;
            default: hdtc_mult_shift = HDTC_SHIFT_X16384;
        endcase
    endfunction

endpackage

// ===== design/hdtc_timer_if.sv
`timescale 1ns/10ps
// control side drives the settings, timer side returns the update strobe
interface hdtc_timer_if;
    logic ce;
    logic pd_tick;
    logic run;
    logic [1:0] mult_sel;
    logic [7:0] count;
    logic tick;
    modport ctrl (output ce, pd_tick, run, mult_sel, count, input tick);
    modport timer (input ce, pd_tick, run, mult_sel, count, output tick);
endinterface

// ===== design/hdtc_rate_timer.sv
`timescale 1ns/10ps
module hdtc_rate_timer
    import hdtc_pkg::*;
#(
    parameter int CNT_W = HDTC_CNT_W
) (
    input wire logic hclk, // system clock
    input wire logic hresetn, // async reset, active low
    hdtc_timer_if.timer tif // settings in, update strobe out
);
    localparam int PER_W = CNT_W + HDTC_SHIFT_MAX;

    if (CNT_W < 1 || CNT_W > HDTC_CNT_W) begin : g_chk
        $error("hdtc_rate_timer: CNT_W out of range");
    end

    typedef struct packed {
        logic [PER_W-1:0] cnt;
        logic tick;
    } hdtc_tstate_t;

    hdtc_tstate_t r;
    hdtc_tstate_t next_r;
    logic [PER_W-1:0] per;
    logic [PER_W-1:0] per_m1;

    // period = multiplier * count, counted in phase-detector cycles
    assign per = PER_W'(tif.count[CNT_W-1:0]) << hdtc_mult_shift(tif.mult_sel);
    assign per_m1 = per - PER_W'(1);
    assign tif.tick = r.tick;

    ////////////////////////////////////////////////////////////////////////
    // a count of zero never fires; >= copes with a period cut on the fly
    always_comb begin
        next_r = r;
        next_r.tick = 1'b0;
        if (!tif.run) begin
            next_r.cnt = '0;
        end else if (tif.pd_tick && per != '0) begin
            if (r.cnt >= per_m1) begin
                next_r.cnt = '0;
                next_r.tick = 1'b1; // R5
            end else begin
                next_r.cnt = r.cnt + PER_W'(1);
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '0;
        end else if (tif.ce) begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_tick_spacing: assert property (@(posedge hclk) disable iff (!hresetn)
        r.tick && $past(tif.ce)
        |-> $past(tif.pd_tick) && $past(r.cnt) >= $past(per_m1)) // R5
        else $error("update strobe without a full period");
    a_mult_values: assert property (@(posedge hclk) disable iff (!hresetn)
        tif.mult_sel == 2'h1 |-> per == PER_W'(tif.count) * PER_W'(64)) // R4
        else $error("multiplier code 1 is not 64");

endmodule

// ===== test/hdtc_holdover_ctrl_tb.sv
`timescale 1ns/10ps
module hdtc_holdover_ctrl_tb
    import hdtc_pkg::*;
    ;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, irq, holdover_active, input_invalid;
    logic clk_switch_event;
    logic [31:0] hrdata;
    logic [9:0] dac_code;
    logic pd_tick = 1'b1;
    logic pll1_locked = 1'b1;
    logic hce = 1'b1;
    logic tune_above_dac = 1'b1;
    int n_fail = 0;
    int n_checks = 0;
    int per;
    logic [9:0] last;
    logic [31:0] rv;

    always #4 hclk = ~hclk;

    hdtc_holdover_ctrl DUT (
        .hclk(hclk), .hresetn(hresetn), .hce(hce), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .pd_tick(pd_tick),
        .pll1_locked(pll1_locked), .tune_above_dac(tune_above_dac),
        .dac_code(dac_code), .holdover_active(holdover_active),
        .input_invalid(input_invalid),
        .clk_switch_event(clk_switch_event), .irq(irq)
    );

    ////////////////////////////////////////////////////////////////////////
    // verdict, reached from the main sequence and from any timeout
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic give_up(input string what);
        n_fail++;
        $display("unexpected timeout waiting for %s", what);
        results();
    endtask

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // one ahb-lite single transfer; the master never assumes a latency
    task automatic bus(input logic [9:0] idx, input logic wr,
                       input logic [2:0] sz, input logic [31:0] wd,
                       output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {20'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= sz;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 100) begin
            @(posedge hclk);
            n++;
        end
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 100) begin
            @(posedge hclk);
            n++;
        end
        rd = hrdata;
        if (n >= 100) give_up("hready");
        check("hresp", {31'h0, hresp}, 32'h0);
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        logic [31:0] x;
        bus(idx, 1'b1, 3'h2, {24'h0, d}, x);
    endtask

    task automatic rd_chk(input string name, input logic [9:0] idx,
                          input logic [7:0] exp);
        logic [31:0] x;
        bus(idx, 1'b0, 3'h2, 32'h0, x);
        check(name, x, {24'h0, exp});
    endtask

    // edges until the dac code moves; two calls give an exact period
    task automatic next_change(output int cyc);
        logic [9:0] p;
        cyc = 0;
        p = dac_code;
        do begin
            @(posedge hclk);
            cyc++;
        end while (dac_code === p && cyc < 40000);
        if (cyc >= 40000) give_up("dac update");
    endtask

    task automatic wait_event;
        int n;
        n = 0;
        while (clk_switch_event !== 1'b1 && n < 20) begin
            @(posedge hclk);
            n++;
        end
        if (n >= 20) give_up("switch event");
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge hclk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        check("dac reset", {22'h0, dac_code}, 32'h200);
        // register reset values, read-only places, unmapped space
        rd_chk("upper", HDTC_IDX_MAN_UPPER, 8'h06);
        rd_chk("lower", HDTC_IDX_MAN_LOWER, 8'h00);
        rd_chk("gnd trip", HDTC_IDX_GND_TRIP, 8'h00);
        rd_chk("mult sup", HDTC_IDX_MULT_SUP, 8'h00);
        rd_chk("count", HDTC_IDX_RATE_CNT, 8'h7F);
        rd_chk("switch", HDTC_IDX_SWITCH_CTRL, 8'h00);
        rd_chk("status", HDTC_IDX_STATUS, 8'h00);
        rd_chk("mask", HDTC_IDX_MASK, 8'h00);
        rd_chk("tracked", HDTC_IDX_TRACKED, 8'h80);
        wr(HDTC_IDX_TRACKED, 8'h11);
        rd_chk("tracked ro", HDTC_IDX_TRACKED, 8'h80);
        wr(10'h170, 8'h55);
        rd_chk("unmapped", 10'h170, 8'h00);
        $display("test reset values done");

        // manual level under forced holdover, then tracked value
        wr(HDTC_IDX_MAN_LOWER, 8'hA5);
        bus(HDTC_IDX_MAN_LOWER, 1'b1, 3'h0, 32'h3C, rv);
        rd_chk("lower", HDTC_IDX_MAN_LOWER, 8'hA5);
        wr(HDTC_IDX_MAN_UPPER, 8'h0F);
        rd_chk("upper", HDTC_IDX_MAN_UPPER, 8'h0F);
        settle(2);
        check("dac manual", {22'h0, dac_code}, 32'h3A5);
        check("forced", {31'h0, holdover_active}, 32'h1);
        wr(HDTC_IDX_MAN_UPPER, 8'h09);
        settle(2);
        check("dac tracked", {22'h0, dac_code}, 32'h200);
        wr(HDTC_IDX_MAN_UPPER, 8'h00);
        settle(2);
        check("released", {31'h0, holdover_active}, 32'h0);
        $display("test manual level done");

        // ground trip at the boundary: tracked[9:4] is 32
        wr(HDTC_IDX_MASK, 8'h07);
        wr(HDTC_IDX_GND_TRIP, 8'h1F);
        wr(HDTC_IDX_SWITCH_CTRL, 8'h04);
        rd_chk("switch on", HDTC_IDX_SWITCH_CTRL, 8'h04);
        settle(4);
        check("no gnd trip", {31'h0, input_invalid}, 32'h0);
        wr(HDTC_IDX_GND_TRIP, 8'h20);
        wait_event();
        settle(2);
        check("gnd invalid", {31'h0, input_invalid}, 32'h1);
        check("gnd holdover", {31'h0, holdover_active}, 32'h1);
        check("irq set", {31'h0, irq}, 32'h1);
        rd_chk("gnd status", HDTC_IDX_STATUS, 8'h01);
        settle(2);
        check("irq clear", {31'h0, irq}, 32'h0);
        wr(HDTC_IDX_SWITCH_CTRL, 8'h00);
        wr(HDTC_IDX_GND_TRIP, 8'h00);
        settle(2);
        check("rail off", {31'h0, input_invalid}, 32'h0);
        $display("test ground trip done");

        // supply trip at the boundary: 32 >= 63 - 31
        wr(HDTC_IDX_MULT_SUP, 8'h1E);
        wr(HDTC_IDX_SWITCH_CTRL, 8'h04);
        settle(4);
        check("no sup trip", {31'h0, input_invalid}, 32'h0);
        wr(HDTC_IDX_MULT_SUP, 8'h1F);
        wait_event();
        settle(2);
        check("sup invalid", {31'h0, input_invalid}, 32'h1);
        rd_chk("sup status", HDTC_IDX_STATUS, 8'h02);
        wr(HDTC_IDX_SWITCH_CTRL, 8'h00);
        wr(HDTC_IDX_MULT_SUP, 8'h00);
        $display("test supply trip done");

        // a zero count never updates the tracked value
        wr(HDTC_IDX_RATE_CNT, 8'h00);
        wr(HDTC_IDX_MAN_UPPER, 8'h10);
        last = dac_code;
        settle(40);
        check("count zero", {22'h0, dac_code}, {22'h0, last});

        // update period is multiplier times count for every code
        wr(HDTC_IDX_RATE_CNT, 8'h01);
        for (int m = 0; m < 4; m++) begin
            wr(HDTC_IDX_MULT_SUP, 8'(m << 6));
            next_change(per);
            next_change(per);
            last = dac_code;
            next_change(per);
            check("period", 32'(per), 32'(4 << (4 * m)));
            check("step up", {22'h0, dac_code}, {22'h0, last + 10'h1});
        end
        wr(HDTC_IDX_MULT_SUP, 8'h00);
        wr(HDTC_IDX_RATE_CNT, 8'h03);
        @(posedge hclk);
        tune_above_dac <= 1'b0;
        next_change(per);
        next_change(per);
        last = dac_code;
        next_change(per);
        check("period 12", 32'(per), 32'd12);
        check("step down", {22'h0, dac_code}, {22'h0, last - 10'h1});
        check("irq upd", {31'h0, irq}, 32'h1);
        wr(HDTC_IDX_MASK, 8'h03);
        settle(2);
        check("irq masked", {31'h0, irq}, 32'h0);
        rd_chk("mask", HDTC_IDX_MASK, 8'h03);
        // a low clock enable freezes the tracked code and its timer
        hce <= 1'b0;
        settle(2);
        last = dac_code;
        settle(30);
        check("frozen", {22'h0, dac_code}, {22'h0, last});
        hce <= 1'b1;
        rd_chk("upd status", HDTC_IDX_STATUS, 8'h04);

        // no tracking while the loop is unlocked
        @(posedge hclk);
        pll1_locked <= 1'b0;
        settle(2);
        last = dac_code;
        settle(40);
        check("unlocked", {22'h0, dac_code}, {22'h0, last});
        $display("test tracking rate done");
        results();
    end
endmodule
